// ### hdl/dco_map.svh
`ifndef DCO_MAP_SVH
`define DCO_MAP_SVH

// Register byte addresses, decoded on the low address byte.
`define DCO_A_PWR 8'h00
`define DCO_A_CFG0 8'h04
`define DCO_A_CFG1 8'h08
`define DCO_A_CTL 8'h0c
`define DCO_A_RCAUSE 8'h10
`define DCO_A_IREQ 8'h14

// Power control fields.
`define DCO_PWR_EN0 0
`define DCO_PWR_EN1 1
`define DCO_PWR_RST 2'h0

// Per-channel configuration fields.
`define DCO_CFG_PSEL 0
`define DCO_CFG_NSEL 2
`define DCO_CFG_PREF 4
`define DCO_CFG_SPD 5
`define DCO_CFG_HYS 7
`define DCO_CFG_INV 9
`define DCO_CFG_W 10
`define DCO_CFG_RST 10'h000
`define DCO_HYS_MAX 2'h2

// Comparator control fields.
`define DCO_CTL_WIN 0
`define DCO_CTL_IEN 1
`define DCO_CTL_PIN 3
`define DCO_CTL_STATE 8
`define DCO_CTL_RST 5'h00

// Reset cause and request fields.
`define DCO_RC_STOP 0
`define DCO_IREQ_CMP 0

`endif

// ### hdl/dco_pkg.sv
package dco_pkg;

	typedef logic [1:0] dco_sel_t;

	typedef enum logic [1:0] {
		DCO_WIN_INSIDE = 2'h0,
		DCO_WIN_BELOW = 2'h1,
		DCO_WIN_ABOVE = 2'h2
	} dco_win_e;

endpackage

// ### hdl/dco_top.sv
// Behaviour
// - Two identical comparator channels, logic replicated per channel, not shared.
// - A channel runs only while its enable bit in power control is set.
// - Invert clear: output high when positive input exceeds negative input.
// - Invert set: output low when positive input exceeds negative input.
// - Combined output is OR of both channel outputs, offered as event source.
// - Software reads current comparator output state in the control register.
// - Each output feeds interrupt request, routable pin and event fabric.
// - Window enable set puts both channels into coordinated window detection.
// - Each channel has a four-way positive input select field.
// - Negative source chosen by negative select field plus reference enable bit.
// - Speed select has four settings, hysteresis select three, both writable.
// - Window status: below 01, inside 00, above 10; first high inside only.
// - In stop, enabled comparator interrupt wakes, sets stop flag and request bit.
//
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dco_map.svh"

module dco_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [1:0] cmp_raw,
	input wire logic stop_mode,
	output logic [1:0] channel_enable,
	output logic [3:0] positive_input_select,
	output logic [3:0] negative_input_select,
	output logic [1:0] prog_reference_enable,
	output logic [3:0] speed_power_select,
	output logic [3:0] input_deadband_select,
	output logic first_output_pin,
	output logic first_output_pin_oe,
	output logic second_output_pin,
	output logic second_output_pin_oe,
	output logic first_event,
	output logic second_event,
	output logic either_output_or,
	output logic [1:0] irq_req,
	output logic stop_recover
);

	logic [1:0] pwr_q;
	logic [`DCO_CFG_W-1:0] cfg_q [2];
	logic [4:0] ctl_q;
	logic rc_stop_q;
	logic ireq_q;
	logic wr_q;
	logic rd_q;
	logic rdv_q;
	logic [7:0] addr_q;
	logic [31:0] hrdata_q;
	logic [1:0] sync1_q;
	logic [1:0] sync2_q;
	logic [1:0] out_q;
	logic or_q;
	logic [1:0] prev_q;
	logic [1:0] irq_q;
	logic stop_rec_q;
	logic [1:0] state_q;
	logic [1:0] live;
	logic [1:0] pol;
	logic [1:0] out_d;
	dco_pkg::dco_sel_t state_d;
	logic win;
	logic [1:0] rise;
	logic cmp_event;
	logic [31:0] rd_mux;
	logic addr_ok;

	// Clamps the hysteresis field so the unused fourth code never reaches the cell.
	function automatic logic [`DCO_CFG_W-1:0] cfg_fix(input logic [31:0] w);
		logic [`DCO_CFG_W-1:0] v;
		v = w[`DCO_CFG_W-1:0];
		if (v[`DCO_CFG_HYS+1:`DCO_CFG_HYS] == 2'h3) begin
			v[`DCO_CFG_HYS+1:`DCO_CFG_HYS] = `DCO_HYS_MAX;
		end
		return v;
	endfunction

	// Widens a channel configuration word for the read mux.
	function automatic logic [31:0] cfg_word(input logic [`DCO_CFG_W-1:0] c);
		return {{(32-`DCO_CFG_W){1'b0}}, c};
	endfunction

	// Write strobe for one register offset, shared by every writable register.
	function automatic logic wr_hit(input logic wr, input logic [7:0] at, input logic [7:0] a);
		return wr && at == a;
	endfunction

	// Two agreeing decisions put the signal outside the window on one side.
	function automatic dco_pkg::dco_sel_t win_state(input logic [1:0] p);
		dco_pkg::dco_sel_t s;
		case (p)
			2'h0: begin
				s = dco_pkg::DCO_WIN_BELOW;
			end
			2'h3: begin
				s = dco_pkg::DCO_WIN_ABOVE;
			end
			default: begin
				s = dco_pkg::DCO_WIN_INSIDE;
			end
		endcase
		return s;
	endfunction

	assign win = ctl_q[`DCO_CTL_WIN];
	assign addr_ok = hsel && htrans[1];
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	// Reads take one wait state so a read never sees a write still in flight.
	assign hreadyout = !(rd_q && !rdv_q);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
		end else if (hready) begin
			wr_q <= addr_ok && hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q <= 1'b0;
		end else if (hready) begin
			rd_q <= addr_ok && !hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdv_q <= 1'b0;
		end else if (hready) begin
			rdv_q <= 1'b0;
		end else if (rd_q) begin
			rdv_q <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= 8'h00;
		end else if (hready) begin
			addr_q <= haddr[7:0];
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (addr_q)
			`DCO_A_PWR: begin
				rd_mux[1:0] = pwr_q;
			end
			`DCO_A_CFG0: begin
				rd_mux = cfg_word(cfg_q[0]);
			end
			`DCO_A_CFG1: begin
				rd_mux = cfg_word(cfg_q[1]);
			end
			`DCO_A_CTL: begin
				rd_mux[4:0] = ctl_q;
				rd_mux[`DCO_CTL_STATE+1:`DCO_CTL_STATE] = state_q;
			end
			`DCO_A_RCAUSE: begin
				rd_mux[`DCO_RC_STOP] = rc_stop_q;
			end
			`DCO_A_IREQ: begin
				rd_mux[`DCO_IREQ_CMP] = ireq_q;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (rd_q && !rdv_q) begin
			hrdata_q <= rd_mux;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwr_q <= `DCO_PWR_RST;
		end else if (wr_hit(wr_q, addr_q, `DCO_A_PWR)) begin
			pwr_q <= hwdata[1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_q <= `DCO_CTL_RST;
		end else if (wr_hit(wr_q, addr_q, `DCO_A_CTL)) begin
			ctl_q <= hwdata[4:0];
		end
	end

	// A wake event in the same cycle as a clearing write keeps the flag set.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rc_stop_q <= 1'b0;
		end else if (stop_mode && cmp_event) begin
			rc_stop_q <= 1'b1;
		end else if (wr_hit(wr_q, addr_q, `DCO_A_RCAUSE) && hwdata[`DCO_RC_STOP]) begin
			rc_stop_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ireq_q <= 1'b0;
		end else if (cmp_event) begin
			ireq_q <= 1'b1;
		end else if (wr_hit(wr_q, addr_q, `DCO_A_IREQ) && hwdata[`DCO_IREQ_CMP]) begin
			ireq_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_rec_q <= 1'b0;
		end else begin
			stop_rec_q <= stop_mode && cmp_event;
		end
	end

	// The raw inputs are asynchronous; first stage feeds only the second.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= 2'h0;
		end else begin
			sync1_q <= cmp_raw;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync2_q <= 2'h0;
		end else begin
			sync2_q <= sync1_q;
		end
	end

	for (genvar i = 0; i < 2; i++) begin : g_ch
		// Each channel carries its own configuration register and gating.
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				cfg_q[i] <= `DCO_CFG_RST;
			end else if (wr_hit(wr_q, addr_q, i == 0 ? `DCO_A_CFG0 : `DCO_A_CFG1)) begin
				cfg_q[i] <= cfg_fix(hwdata);
			end
		end

		// A powered-down channel reads low whatever the cell leaves behind.
		assign live[i] = sync2_q[i] && pwr_q[i];
		// The cell reports positive above negative as high.
		assign pol[i] = live[i] ^ cfg_q[i][`DCO_CFG_INV];

		assign channel_enable[i] = pwr_q[i];
		assign positive_input_select[2*i+1:2*i] =
			cfg_q[i][`DCO_CFG_PSEL+1:`DCO_CFG_PSEL];
		assign negative_input_select[2*i+1:2*i] =
			cfg_q[i][`DCO_CFG_NSEL+1:`DCO_CFG_NSEL];
		assign prog_reference_enable[i] = cfg_q[i][`DCO_CFG_PREF];
		assign speed_power_select[2*i+1:2*i] =
			cfg_q[i][`DCO_CFG_SPD+1:`DCO_CFG_SPD];
		assign input_deadband_select[2*i+1:2*i] =
			cfg_q[i][`DCO_CFG_HYS+1:`DCO_CFG_HYS];
	end

	always_comb begin
		out_d = 2'h0;
		state_d = 2'h0;
		if (win) begin
			out_d[0] = pol[0] ^ pol[1];
			out_d[1] = 1'b0;
			state_d = win_state(pol);
		end else begin
			out_d = pol;
			state_d = {pol[0], pol[1]};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_q <= 2'h0;
		end else begin
			out_q <= out_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			or_q <= 1'b0;
		end else begin
			or_q <= out_d[0] | out_d[1];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= 2'h0;
		end else begin
			state_q <= state_d;
		end
	end

	// Rising output edges only, so a steady high level raises one request.
	assign rise = out_q & ~prev_q;
	assign cmp_event = |(rise & ctl_q[`DCO_CTL_IEN+1:`DCO_CTL_IEN]);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_q <= 2'h0;
		end else begin
			prev_q <= out_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_q <= 2'h0;
		end else begin
			irq_q <= rise & ctl_q[`DCO_CTL_IEN+1:`DCO_CTL_IEN];
		end
	end

	assign irq_req = irq_q;
	assign stop_recover = stop_rec_q;
	assign first_output_pin = out_q[0];
	assign second_output_pin = out_q[1];
	assign first_output_pin_oe = ctl_q[`DCO_CTL_PIN];
	assign second_output_pin_oe = ctl_q[`DCO_CTL_PIN+1];
	assign first_event = out_q[0];
	assign second_event = out_q[1];
	assign either_output_or = or_q;

endmodule

`default_nettype wire

// ### tb/dco_cmp_model.sv
`timescale 1ns/1ps
`default_nettype none
module dco_cmp_model (
	input wire logic [1:0] enable,
	input wire logic [1:0] above,
	output logic [1:0] raw
);
	// A powered-down cell makes no valid decision, so it shows the opposite level.
	assign raw = (enable & above) | (~enable & ~above);
endmodule
`default_nettype wire

// ### tb/dco_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dco_top_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic stop_mode,
	input wire logic first_output_pin,
	input wire logic second_output_pin,
	input wire logic first_event,
	input wire logic second_event,
	input wire logic either_output_or,
	input wire logic [1:0] irq_req,
	input wire logic stop_recover
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire logic take = hsel && htrans[1] && hready;
	sequence s_rd_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	a_or_output: assert property (either_output_or
		== (first_output_pin | second_output_pin))
		else $error("combined output wrong");
	a_event_copy: assert property (first_event == first_output_pin
		&& second_event == second_output_pin)
		else $error("event differs from pin");
	a_irq_first: assert property (irq_req[0] |-> $past(first_output_pin)
		&& !$past(first_output_pin, 2))
		else $error("first request without rising output");
	a_irq_second: assert property (irq_req[1] |-> $past(second_output_pin)
		&& !$past(second_output_pin, 2))
		else $error("second request without rising output");
	a_wake_cause: assert property (stop_recover |-> (|irq_req))
		else $error("recovery without request");
	a_wake_stop: assert property (stop_recover |-> $past(stop_mode))
		else $error("recovery outside stop");
	a_rd_wait: assert property (take && !hwrite |=> s_rd_wait)
		else $error("read wait state wrong");
	a_wr_nowait: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
endmodule
bind dco_top dco_top_monitor dco_top_monitor_i (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
	.hreadyout, .stop_mode, .first_output_pin, .second_output_pin, .first_event, .second_event,
	.either_output_or, .irq_req, .stop_recover);
`default_nettype wire

// ### tb/dco_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dco_map.svh"
module dco_top_tb;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, stop_mode = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0, above = 0, cmp_raw, chen, irq_req, pref;
	logic [3:0] psel, nsel, spd, hys;
	logic hreadyout, pin0, pin1, oe0, oe1, ev0, ev1, orr, wake;
	int fail_count = 0, tests_run = 0;
	always #4 hclk = ~hclk;
	dco_cmp_model dco_cmp_model_i (.enable(chen), .above(above), .raw(cmp_raw));
	dco_top dco_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .cmp_raw(cmp_raw),
		.stop_mode(stop_mode), .channel_enable(chen), .positive_input_select(psel),
		.negative_input_select(nsel), .prog_reference_enable(pref), .speed_power_select(spd),
		.input_deadband_select(hys), .first_output_pin(pin0), .first_output_pin_oe(oe0),
		.second_output_pin(pin1), .second_output_pin_oe(oe1), .first_event(ev0),
		.second_event(ev1), .either_output_or(orr), .irq_req(irq_req), .stop_recover(wake));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task put(input logic [1:0] v);
		@(posedge hclk);
		above <= v;
		repeat (4) @(posedge hclk);
		#1;
	endtask
	task t_regs;
		bus(0, `DCO_A_PWR, 0);
		chk(rd, 0);
		bus(1, `DCO_A_CFG0, 32'h3ff);
		bus(0, `DCO_A_CFG0, 0);
		chk(rd, 32'h37f);
		chk({psel[1:0], nsel[1:0], pref[0], spd[1:0], hys[1:0]}, 9'h1fe);
		bus(1, `DCO_A_CTL, 32'h18);
		@(posedge hclk);
		chk({oe0, oe1}, 2'h3);
		bus(1, 8'h20, 32'h1);
		bus(0, 8'h20, 0);
		chk(rd, 0);
		bus(1, `DCO_A_CFG0, 0);
	endtask
	task t_polarity;
		logic [1:0] e;
		bus(1, `DCO_A_PWR, 3);
		for (int i = 0; i < 8; i++) begin
			bus(1, `DCO_A_CFG0, {22'h0, i[2], 9'h0});
			bus(1, `DCO_A_CFG1, {22'h0, i[2], 9'h0});
			put(i[1:0]);
			e = i[1:0] ^ {2{i[2]}};
			chk({pin1, pin0}, e);
			chk(orr, |e);
			chk({ev1, ev0}, e);
			bus(0, `DCO_A_CTL, 0);
			chk(rd[9:8], {e[0], e[1]});
		end
	endtask
	task t_power;
		bus(1, `DCO_A_CFG0, 0);
		bus(1, `DCO_A_CFG1, 0);
		bus(1, `DCO_A_PWR, 2);
		put(3);
		chk({pin1, pin0}, 2'h2);
		chk(chen, 2'h2);
		put(2);
		chk({pin1, pin0}, 2'h2);
	endtask
	task t_irq;
		bus(1, `DCO_A_PWR, 3);
		bus(1, `DCO_A_CTL, 2);
		put(0);
		bus(1, `DCO_A_RCAUSE, 1);
		bus(1, `DCO_A_IREQ, 1);
		stop_mode <= 1'b1;
		put(1);
		chk(irq_req, 2'h1);
		chk(wake, 1'b1);
		@(posedge hclk);
		stop_mode <= 1'b0;
		bus(0, `DCO_A_RCAUSE, 0);
		chk(rd, 1);
		bus(0, `DCO_A_IREQ, 0);
		chk(rd, 1);
		bus(1, `DCO_A_IREQ, 1);
		bus(0, `DCO_A_IREQ, 0);
		chk(rd, 0);
		bus(1, `DCO_A_RCAUSE, 1);
		bus(0, `DCO_A_RCAUSE, 0);
		chk(rd, 0);
		bus(1, `DCO_A_CTL, 4);
		put(2);
		chk(irq_req, 2'h2);
		chk(wake, 1'b0);
	endtask
	task t_window;
		bus(1, `DCO_A_CTL, 1);
		for (int ab = 0; ab < 4; ab++) begin
			put(ab[1:0]);
			chk({pin1, pin0}, ab[0] ^ ab[1]);
			chk(orr, ab[0] ^ ab[1]);
			bus(0, `DCO_A_CTL, 0);
			chk(rd[9:8], ab == 0 ? dco_pkg::DCO_WIN_BELOW : ab == 3 ? dco_pkg::DCO_WIN_ABOVE :
				dco_pkg::DCO_WIN_INSIDE);
		end
	endtask
	task final_report;
		$display("comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_polarity();
		t_power();
		t_irq();
		t_window();
		final_report();
	end
	initial begin
		repeat (5000) @(posedge hclk);
		fail_count++;
		final_report();
	end
endmodule
`default_nettype wire
